/* design/mth_map.svh */
`ifndef MTH_MAP_SVH
`define MTH_MAP_SVH
`define MTH_A_CTRL 8'h00
`define MTH_A_DELAY1 8'h04
`define MTH_A_DELAY2 8'h08
`define MTH_A_INTEG 8'h0C
`define MTH_A_RANGE 8'h10
`define MTH_A_EOMW 8'h14
`define MTH_A_SHIFT 8'h18
`define MTH_A_CMD 8'h1C
`define MTH_A_STATUS 8'h20
`define MTH_B_MEASURE_TRIGGER_N_INT 0
`define MTH_B_MEASURE_TRIGGER_N_RISE 1
`define MTH_B_EOM_PULSE 2
`define MTH_B_OVC 3
`define MTH_B_CI_PULSE 4
`define MTH_B_CI_LONG 5
`define MTH_B_SHIFT_EN 6
`define MTH_B_LOW_POWER 7
`define MTH_B_STATS 8
`define MTH_B_CMD_ENTER 0
`define MTH_B_CMD_SHINIT 1
`define MTH_B_CMD_COMP 2
`define MTH_CTRL_RST 9'h000
`define MTH_DELAY_RST 11'h000
`define MTH_INTEG_RST 11'h001
`define MTH_EOMW_RST 7'h01
`define MTH_CLK_PERIOD_NS 10
`define MTH_TICK_US 100
`define MTH_TICK_CYCLES (`MTH_TICK_US * 1000 / `MTH_CLK_PERIOD_NS)
`define MTH_TICKS_PER_MS (1000 / `MTH_TICK_US)
`define MTH_CAL_PERIOD_MIN 10
`define MTH_US_PER_MIN 60000000
`define MTH_CAL_PERIOD_TICKS (`MTH_CAL_PERIOD_MIN * `MTH_US_PER_MIN / `MTH_TICK_US)
`define MTH_CAL_TIME_MS 130
`define MTH_CAL_TICKS (`MTH_CAL_TIME_MS * `MTH_TICKS_PER_MS)
`define MTH_CALC_TIME_US 100
`define MTH_CALC_TICKS (`MTH_CALC_TIME_US / `MTH_TICK_US)
`define MTH_CALC_EXTRA_TICKS 1
`define MTH_CI_SHORT_US 100
`define MTH_CI_LONG_US 300
`define MTH_PHASE_MAX_MS 100
`define MTH_PHASE_MAX_TICKS (`MTH_PHASE_MAX_MS * `MTH_TICKS_PER_MS)
`define MTH_MEAS_MIN_US 100
`define MTH_MEAS_MIN_TICKS (`MTH_MEAS_MIN_US / `MTH_TICK_US)
`define MTH_EOMW_MIN_MS 1
`define MTH_EOMW_MAX_MS 100
`endif

/* design/mth_pkg.sv */
package mth_pkg;
  typedef enum logic [3:0] {
    MTH_S_INIT,
    MTH_S_IDLE,
    MTH_S_CAL,
    MTH_S_DELAY1,
    MTH_S_DELAY2,
    MTH_S_MEAS,
    MTH_S_CALC,
    MTH_S_DONE
  } mth_state_e;
  typedef struct packed {
    logic above;
    logic pass;
    logic below;
    logic meas_error;
    logic contact_high;
    logic contact_low;
  } mth_result_s;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } mth_bus_s;
endpackage : mth_pkg

/* design/mth_timer.sv */
`timescale 1ns/1ps
`include "mth_map.svh"
module mth_timer #(
  parameter int W = 11,
  parameter int TICK_CYCLES = `MTH_TICK_CYCLES
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic load_in,
  input wire logic [W-1:0] value_in,
  output logic done_out
);
  localparam int PW = $clog2(TICK_CYCLES + 1);
  logic [PW-1:0] pre_reg;
  logic [PW-1:0] pre_next;
  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  // prescaler restarts on load so a phase never runs short
  always_comb
  begin
    pre_next = pre_reg;
    cnt_next = cnt_reg;
    if (load_in)
    begin
      pre_next = '0;
      cnt_next = value_in;
    end
    else if (cnt_reg != '0)
    begin
      if (pre_reg == PW'(TICK_CYCLES - 1))
      begin
        pre_next = '0;
        cnt_next = cnt_reg - 1'b1;
      end
      else
        pre_next = pre_reg + 1'b1;
    end
  end
  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      pre_reg <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      pre_reg <= pre_next;
      cnt_reg <= cnt_next;
    end
  end
  assign done_out = (cnt_reg == '0);
endmodule : mth_timer

/* design/mth_shift.sv */
`timescale 1ns/1ps
module mth_shift #(
  parameter int DEPTH = 15,
  parameter int CW = 4
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic clear_in,
  input wire logic advance_in,
  input wire logic [CW-1:0] count_in,
  input wire logic data_in,
  output logic data_out
);
  logic [DEPTH-1:0] line_reg;
  logic [DEPTH-1:0] line_next;
  always_comb
  begin
    line_next = line_reg;
    if (clear_in)
      line_next = '0;
    else if (advance_in)
      line_next = {line_reg[DEPTH-2:0], data_in};
  end
  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
      line_reg <= '0;
    else
      line_reg <= line_next;
  end
  // tap read before the line moves: result of count_in measurements ago
  assign data_out = (count_in == '0) ? data_in : line_reg[count_in - 1'b1];
endmodule : mth_shift

/* design/mth_top.sv */
`timescale 1ns/1ps
`include "mth_map.svh"
module mth_top
  import mth_pkg::*;
#(
  parameter int TICK_CYCLES = `MTH_TICK_CYCLES,
  parameter int CAL_PERIOD_TICKS = `MTH_CAL_PERIOD_TICKS,
  parameter int SHIFT_DEPTH = 15
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  input wire logic measure_trigger_n_in,
  input wire logic ui_lock_in,
  input wire mth_result_s result_in,
  output logic end_of_measure_n_out,
  output logic index_n_out,
  output logic judge_above_n_out,
  output logic judge_pass_n_out,
  output logic judge_below_n_out,
  output logic meas_error_n_out,
  output logic contact_fault_high_n_out,
  output logic contact_fault_low_n_out
);
  localparam logic [7:0] IDLY_NORM [16] = '{8'h0E, 8'h07, 8'h05, 8'h06,
    8'h06, 8'h06, 8'h06, 8'h06, 8'h06, 8'h08, 8'h08, 8'h09, 8'h09, 8'h1B,
    8'h20, 8'h34};
  // low-power column; ranges without a figure fall back to normal
  localparam logic [7:0] IDLY_LOW [16] = '{8'h0E, 8'h06, 8'h06, 8'h06,
    8'h05, 8'h0D, 8'h21, 8'h06, 8'h06, 8'h08, 8'h08, 8'h09, 8'h09, 8'h1B,
    8'h20, 8'h34};
  localparam logic [11:0] PMAX = 12'(`MTH_PHASE_MAX_TICKS);
  localparam logic [11:0] MMIN = 12'(`MTH_MEAS_MIN_TICKS);
  mth_bus_s bus;
  mth_state_e st_reg, st_next;
  logic [8:0] ctrl_reg, ctrl_next;
  logic [10:0] dly1_reg, dly1_next, dly2_reg, dly2_next;
  logic [10:0] integ_reg, integ_next;
  logic [3:0] range_reg, range_next;
  logic [6:0] eomw_reg, eomw_next;
  logic [15:0] shift_reg, shift_next;
  logic [31:0] rdata_reg, rdata_next;
  logic measure_trigger_n_prev_reg, pend_reg, pend_next, pulse_reg, pulse_next;
  logic [7:0] out_reg, out_next;
  logic wr_ctrl, wr_shift, wr_cmd, enter_cmd, shift_clear;
  logic measure_trigger_n_edge, measure_trigger_n_evt, is_int, shift_act, start;
  logic phase_load, phase_done, pulse_load, pulse_done;
  logic cal_load, cal_due;
  logic [10:0] phase_val, pulse_val;
  logic [11:0] d2_full, meas_sum, meas_full;
  logic [3:0] shf_out;
  logic [3:0] raw4;
  logic err_any;
  assign bus = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};
  assign is_int = ctrl_reg[`MTH_B_MEASURE_TRIGGER_N_INT];
  assign wr_ctrl = bus.wr && (bus.addr == `MTH_A_CTRL);
  assign wr_shift = bus.wr && (bus.addr == `MTH_A_SHIFT);
  assign wr_cmd = bus.wr && (bus.addr == `MTH_A_CMD);
  assign enter_cmd = wr_cmd && bus.wdata[`MTH_B_CMD_ENTER];
  assign shift_clear = (wr_shift && (bus.wdata[15:0] != shift_reg))
    || (wr_cmd && bus.wdata[`MTH_B_CMD_SHINIT])
    || (wr_cmd && bus.wdata[`MTH_B_CMD_COMP])
    || (wr_ctrl && bus.wdata[`MTH_B_MEASURE_TRIGGER_N_INT] && !is_int);
  assign shift_act = ctrl_reg[`MTH_B_SHIFT_EN] && !is_int;
  // edge polarity chosen by software
  assign measure_trigger_n_edge = ctrl_reg[`MTH_B_MEASURE_TRIGGER_N_RISE]
    ? (!measure_trigger_n_prev_reg && measure_trigger_n_in)
    : (measure_trigger_n_prev_reg && !measure_trigger_n_in);
  assign measure_trigger_n_evt = measure_trigger_n_edge && !ui_lock_in && !is_int
    && (st_reg != MTH_S_INIT);
  always_comb
  begin
    ctrl_next = ctrl_reg;
    dly1_next = dly1_reg;
    dly2_next = dly2_reg;
    integ_next = integ_reg;
    range_next = range_reg;
    eomw_next = eomw_reg;
    shift_next = shift_reg;
    rdata_next = '0;
    if (bus.wr)
      unique case (bus.addr)
        `MTH_A_CTRL: ctrl_next = bus.wdata[8:0];
        `MTH_A_DELAY1: dly1_next = bus.wdata[10:0];
        `MTH_A_DELAY2: dly2_next = bus.wdata[10:0];
        `MTH_A_INTEG: integ_next = bus.wdata[10:0];
        `MTH_A_RANGE: range_next = bus.wdata[3:0];
        `MTH_A_EOMW: eomw_next = bus.wdata[6:0];
        `MTH_A_SHIFT: shift_next = bus.wdata[15:0];
        default: ;
      endcase
    if (bus.rd)
      unique case (bus.addr)
        `MTH_A_CTRL: rdata_next = {23'h0, ctrl_reg};
        `MTH_A_DELAY1: rdata_next = {21'h0, dly1_reg};
        `MTH_A_DELAY2: rdata_next = {21'h0, dly2_reg};
        `MTH_A_INTEG: rdata_next = {21'h0, integ_reg};
        `MTH_A_RANGE: rdata_next = {28'h0, range_reg};
        `MTH_A_EOMW: rdata_next = {25'h0, eomw_reg};
        `MTH_A_SHIFT: rdata_next = {16'h0, shift_reg};
        `MTH_A_STATUS: rdata_next = {16'h0, out_reg, 2'h0, pend_reg,
          cal_due, st_reg};
        default: rdata_next = '0;
      endcase
  end
  // delay two, with contact improver pulse added
  always_comb
  begin
    d2_full = (dly2_reg > PMAX[10:0]) ? PMAX : {1'b0, dly2_reg};
    if (ctrl_reg[`MTH_B_CI_PULSE])
      d2_full = d2_full + (ctrl_reg[`MTH_B_CI_LONG]
        ? 12'(`MTH_CI_LONG_US / `MTH_TICK_US)
        : 12'(`MTH_CI_SHORT_US / `MTH_TICK_US));
    meas_sum = {1'b0, integ_reg} + 12'(ctrl_reg[`MTH_B_LOW_POWER]
      ? IDLY_LOW[range_reg] : IDLY_NORM[range_reg]);
    meas_full = ctrl_reg[`MTH_B_OVC]
      ? 12'(meas_sum << 1) + d2_full : meas_sum;
    if (meas_full > PMAX)
      meas_full = PMAX;
    else if (meas_full < MMIN)
      meas_full = MMIN;
  end
  always_comb
  begin
    st_next = st_reg;
    pend_next = pend_reg;
    start = 1'b0;
    unique case (st_reg)
      MTH_S_INIT:
        if (enter_cmd)
          st_next = MTH_S_IDLE;
      MTH_S_IDLE:
        if (cal_due)
        begin
          st_next = MTH_S_CAL;
          pend_next = pend_reg || measure_trigger_n_evt;
        end
        else if (is_int || measure_trigger_n_evt || pend_reg)
        begin
          st_next = MTH_S_DELAY1;
          pend_next = 1'b0;
          start = 1'b1;
        end
      MTH_S_CAL:
      begin
        if (measure_trigger_n_evt)
          pend_next = 1'b1;
        if (phase_done)
          st_next = MTH_S_IDLE;
      end
      MTH_S_DELAY1:
        if (phase_done)
          st_next = MTH_S_DELAY2;
      MTH_S_DELAY2:
        if (phase_done)
          st_next = MTH_S_MEAS;
      MTH_S_MEAS:
        if (phase_done)
          st_next = MTH_S_CALC;
      MTH_S_CALC:
        if (phase_done)
          st_next = MTH_S_DONE;
      MTH_S_DONE:
        st_next = MTH_S_IDLE;
    endcase
  end
  // trigger edges in the delay to done states fall through unused
  always_comb
  begin
    phase_val = '0;
    unique case (st_next)
      MTH_S_CAL: phase_val = 11'(`MTH_CAL_TICKS);
      MTH_S_DELAY1: phase_val = (dly1_reg > PMAX[10:0]) ? PMAX[10:0]
        : dly1_reg;
      MTH_S_DELAY2: phase_val = d2_full[10:0];
      MTH_S_MEAS: phase_val = meas_full[10:0];
      MTH_S_CALC: phase_val = 11'(`MTH_CALC_TICKS)
        + (ctrl_reg[`MTH_B_STATS] ? 11'(`MTH_CALC_EXTRA_TICKS)
        : 11'h000);
      default: phase_val = '0;
    endcase
  end
  assign phase_load = (st_next != st_reg) && (phase_val != '0);
  assign cal_load = enter_cmd || (st_reg == MTH_S_CAL && phase_done);
  assign pulse_val = 11'((eomw_reg < 7'(`MTH_EOMW_MIN_MS)) ? 7'(`MTH_EOMW_MIN_MS)
    : (eomw_reg > 7'(`MTH_EOMW_MAX_MS)) ? 7'(`MTH_EOMW_MAX_MS) : eomw_reg)
    * 11'(`MTH_TICKS_PER_MS);
  assign pulse_load = (st_reg == MTH_S_DONE) && !is_int
    && ctrl_reg[`MTH_B_EOM_PULSE];
  assign raw4 = {result_in.above, result_in.pass, result_in.below,
    result_in.meas_error};
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_shift
      mth_shift #(.DEPTH(SHIFT_DEPTH), .CW(4)) u_shift (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .clear_in(shift_clear),
        .advance_in(shift_act && st_reg == MTH_S_CALC && phase_done),
        .count_in(shift_reg[4*(3-gi) +: 4]),
        .data_in(raw4[3-gi]),
        .data_out(shf_out[3-gi])
      );
    end
  endgenerate
  // out_reg: eom, index, above, pass, below, error, contact high, low
  always_comb
  begin
    logic [3:0] j;
    j = shift_act ? shf_out : raw4;
    err_any = j[0] || result_in.contact_high || result_in.contact_low;
    out_next = out_reg;
    pulse_next = pulse_reg;
    if (st_reg == MTH_S_INIT)
    begin
      if (enter_cmd)
        out_next = 8'h3F;
    end
    else if (start)
    begin
      pulse_next = 1'b0;
      out_next[6] = 1'b1;
      if (!is_int)
        out_next = 8'hFF;
    end
    else if (st_reg == MTH_S_MEAS && phase_done)
      out_next[6] = 1'b0;
    else if (st_reg == MTH_S_CALC && phase_done)
    begin
      out_next[5:0] = ~{j[3] && !err_any, j[2] && !err_any,
        j[1] && !err_any, j[0], result_in.contact_high,
        result_in.contact_low};
    end
    else if (st_reg == MTH_S_DONE && !is_int)
    begin
      out_next[7] = 1'b0;
      pulse_next = ctrl_reg[`MTH_B_EOM_PULSE];
    end
    else if (pulse_reg && pulse_done)
    begin
      out_next[7:6] = 2'b11;
      pulse_next = 1'b0;
    end
    if (is_int && st_reg != MTH_S_INIT && !out_reg[7])
    begin
      out_next[7:6] = 2'b11;
      pulse_next = 1'b0;
    end
  end
  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      st_reg <= MTH_S_INIT;
      ctrl_reg <= `MTH_CTRL_RST;
      dly1_reg <= `MTH_DELAY_RST;
      dly2_reg <= `MTH_DELAY_RST;
      integ_reg <= `MTH_INTEG_RST;
      range_reg <= 4'h0;
      eomw_reg <= `MTH_EOMW_RST;
      shift_reg <= 16'h0000;
      rdata_reg <= '0;
      measure_trigger_n_prev_reg <= 1'b1;
      pend_reg <= 1'b0;
      pulse_reg <= 1'b0;
      out_reg <= 8'h00;
    end
    else
    begin
      st_reg <= st_next;
      ctrl_reg <= ctrl_next;
      dly1_reg <= dly1_next;
      dly2_reg <= dly2_next;
      integ_reg <= integ_next;
      range_reg <= range_next;
      eomw_reg <= eomw_next;
      shift_reg <= shift_next;
      rdata_reg <= rdata_next;
      measure_trigger_n_prev_reg <= measure_trigger_n_in;
      pend_reg <= pend_next;
      pulse_reg <= pulse_next;
      out_reg <= out_next;
    end
  end
  mth_timer #(.W(11), .TICK_CYCLES(TICK_CYCLES)) u_phase (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .load_in(phase_load),
    .value_in(phase_val),
    .done_out(phase_done)
  );
  mth_timer #(.W(11), .TICK_CYCLES(TICK_CYCLES)) u_pulse (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .load_in(pulse_load),
    .value_in(pulse_val),
    .done_out(pulse_done)
  );
  // calibration can become due at any time, even mid-measurement; it is acted on only in idle
  mth_timer #(.W(23), .TICK_CYCLES(TICK_CYCLES)) u_cal (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .load_in(cal_load),
    .value_in(23'(CAL_PERIOD_TICKS)),
    .done_out(cal_due)
  );
  assign rdata_out = rdata_reg;
  assign {end_of_measure_n_out, index_n_out, judge_above_n_out,
    judge_pass_n_out, judge_below_n_out, meas_error_n_out,
    contact_fault_high_n_out, contact_fault_low_n_out} = out_reg;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  property p_cal_defer;
    (st_reg == MTH_S_CAL && (measure_trigger_n_evt || pend_reg)) |=> pend_reg;
  endproperty
  a_cal_defer: assert property (p_cal_defer) else $error("trigger lost in cal");
  property p_busy;
    (st_reg == MTH_S_MEAS && measure_trigger_n_edge) |=> st_reg inside {MTH_S_MEAS, MTH_S_CALC};
  endproperty
  a_busy: assert property (p_busy) else $error("trigger restarted measure");
  property p_lock;
    (st_reg == MTH_S_IDLE && ui_lock_in && !is_int && !pend_reg)
      |=> st_reg != MTH_S_DELAY1;
  endproperty
  a_lock: assert property (p_lock) else $error("locked trigger accepted");
  property p_index_eom;
    $rose(end_of_measure_n_out) |-> $rose(index_n_out);
  endproperty
  a_index_eom: assert property (p_index_eom) else $error("index not with eom");
  property p_judge_first;
    $fell(end_of_measure_n_out) |-> $stable(out_reg[5:0])
      && $past(st_reg) == MTH_S_DONE;
  endproperty
  a_judge_first: assert property (p_judge_first) else $error("eom before judge");
  property p_int_eom;
    (is_int && st_reg != MTH_S_INIT) |=> end_of_measure_n_out;
  endproperty
  a_int_eom: assert property (p_int_eom) else $error("eom low in int");
  property p_hold;
    (!end_of_measure_n_out && st_reg != MTH_S_INIT && !start && !is_int
      && !ctrl_reg[`MTH_B_EOM_PULSE]) |=> !end_of_measure_n_out;
  endproperty
  a_hold: assert property (p_hold) else $error("hold eom released");
  property p_poweron;
    (st_reg == MTH_S_INIT) |-> out_reg == 8'h00;
  endproperty
  a_poweron: assert property (p_poweron) else $error("outputs not asserted");
  property p_delays;
    (st_reg == MTH_S_DELAY1 && phase_done) |=> st_reg == MTH_S_DELAY2 ##1
      st_reg inside {MTH_S_DELAY2, MTH_S_MEAS};
  endproperty
  a_delays: assert property (p_delays) else $error("delay order broken");
  property p_int_clear;
    (wr_ctrl && bus.wdata[`MTH_B_MEASURE_TRIGGER_N_INT] && !is_int) |-> shift_clear
      ##1 !shift_act;
  endproperty
  a_int_clear: assert property (p_int_clear) else $error("shift kept in int");
endmodule : mth_top

/* testbench/mth_ctl_model.sv */
`timescale 1ns/1ps
// outside controller: fires one trigger pulse per request
module mth_ctl_model #(
  parameter int LOW_CYC = 20,
  parameter int SETTLE_CYC = 30
) (
  input wire logic clk_in,
  input wire logic fire_in,
  output logic strike_n_out,
  output logic busy_out
);
  int cnt_reg = 0;
  initial
  begin
    strike_n_out = 1'b1;
    busy_out = 1'b0;
  end
  // settle time scaled down to keep the run short
  always @(posedge clk_in)
  begin
    if (fire_in && !busy_out)
    begin
      busy_out <= 1'b1;
      cnt_reg <= SETTLE_CYC + 2 * LOW_CYC;
    end
    else if (busy_out)
    begin
      cnt_reg <= cnt_reg - 1;
      strike_n_out <= !(cnt_reg <= 2 * LOW_CYC && cnt_reg > LOW_CYC);
      busy_out <= cnt_reg > 1;
    end
  end
endmodule : mth_ctl_model

/* testbench/tb.sv */
`timescale 1ns/1ps
`include "mth_map.svh"
module tb;
  import mth_pkg::*;
  localparam int T = 10;
  localparam int LOWC = 2 * T;
  typedef struct packed {
    logic [31:0] v;
    logic [31:0] m;
  } mth_rd_s;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic lock = 1'b0;
  logic fire = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  mth_result_s res = '0;
  wire [31:0] rdata;
  wire end_n;
  wire idx_n;
  wire strike_n;
  wire busy;
  wire [5:0] j;
  int errors = 0;
  int comparisons = 0;
  int cyc = 0;
  int t_enter = 0;
  mth_rd_s rq[$];
  mth_rd_s rdq;
  logic [5:0] jq[$];
  logic rd_d = 1'b0;
  logic end_p = 1'b0;
  logic [5:0] j_p = 6'h00;
  // ctrl, delay1, delay2, integ, range, expected ticks
  int cs[5][6] = '{'{0, 0, 0, 1, 0, 16}, '{8, 3, 2, 2, 15, 116},
    '{18, 1, 1, 1, 3, 11}, '{176, 0, 0, 1, 6, 38},
    '{260, 0, 0, 1, 1, 10}};
  always #5 clk_in = ~clk_in;
  mth_top #(.TICK_CYCLES(T), .CAL_PERIOD_TICKS(1500)) uut (
    .clk_in(clk_in), .nrst_in(nrst_in), .addr_in(addr),
    .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
    .measure_trigger_n_in(strike_n), .ui_lock_in(lock),
    .result_in(res), .end_of_measure_n_out(end_n),
    .index_n_out(idx_n), .judge_above_n_out(j[5]),
    .judge_pass_n_out(j[4]), .judge_below_n_out(j[3]),
    .meas_error_n_out(j[2]), .contact_fault_high_n_out(j[1]),
    .contact_fault_low_n_out(j[0]));
  mth_ctl_model #(.LOW_CYC(LOWC), .SETTLE_CYC(3 * T)) ctl (
    .clk_in(clk_in), .fire_in(fire), .strike_n_out(strike_n),
    .busy_out(busy));
  task automatic end_of_test();
    if (errors == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("FAIL %s exp %0h seen %0h", nm, exp, seen);
    end
  endtask : chk
  function automatic logic [5:0] ex(mth_result_s r, logic pv);
    logic e;
    e = r.meas_error | r.contact_high | r.contact_low;
    return {e | ~r.above, e | ~pv, e | ~r.below, ~r.meas_error,
      ~r.contact_high, ~r.contact_low};
  endfunction : ex
  task automatic wr_reg(logic [7:0] a, logic [31:0] d);
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(logic [7:0] a, logic [31:0] v, logic [31:0] m);
    rq.push_back('{v, m});
    @(posedge clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
  endtask : rd_chk
  task automatic kick();
    while (busy !== 1'b0)
      @(posedge clk_in);
    fire <= 1'b1;
    @(posedge clk_in);
    fire <= 1'b0;
    @(posedge clk_in);
  endtask : kick
  task automatic cfg(int k);
    wr_reg(`MTH_A_CTRL, cs[k][0]);
    wr_reg(`MTH_A_DELAY1, cs[k][1]);
    wr_reg(`MTH_A_DELAY2, cs[k][2]);
    wr_reg(`MTH_A_INTEG, cs[k][3]);
    wr_reg(`MTH_A_RANGE, cs[k][4]);
  endtask : cfg
  task automatic run(int n, int alo, int ahi, logic pulse, logic dbl,
    logic cal, mth_result_s r, logic pv);
    int t;
    int t0;
    res <= r;
    jq.push_back(ex(r, pv));
    kick();
    t = 0;
    while (strike_n !== 1'b0 && t < 500)
    begin
      @(posedge clk_in);
      t++;
    end
    if (cal)
      // calibration stays flagged due until it has finished
      rd_chk(`MTH_A_STATUS, 32'h32, 32'h3F);
    t = 0;
    while (end_n !== 1'b1 && t < 20000)
    begin
      @(posedge clk_in);
      t++;
    end
    t0 = cyc;
    chk("accept", t >= alo && t <= ahi, 1);
    if (dbl)
      kick();
    t = 0;
    while (end_n !== 1'b0 && t < 2000)
    begin
      @(posedge clk_in);
      t++;
    end
    // length counted from acceptance, so a second kick does not shorten it
    t = cyc - t0;
    chk("length", t >= n * T - 2 && t <= n * T + 9, 1);
    t = 0;
    if (pulse)
    begin
      while (end_n !== 1'b1 && t < 500)
      begin
        @(posedge clk_in);
        t++;
      end
      chk("pulse", t >= 98 && t <= 105, 1);
    end
    else
    begin
      repeat (3 * T) @(posedge clk_in);
      chk("held", end_n, 0);
    end
  endtask : run
  // results are judged where the strobe falls
  always @(posedge clk_in)
  begin
    rd_d <= rd;
    end_p <= end_n;
    j_p <= j;
    cyc <= cyc + 1;
    if (rd_d)
    begin
      rdq = rq.pop_front();
      chk("rdata", rdata & rdq.m, rdq.v);
    end
    if (nrst_in && end_p === 1'b1 && end_n === 1'b0)
    begin
      chk("settled", j, j_p);
      if (jq.size() > 0)
        chk("judge", j, jq.pop_front());
      else
        chk("extra", 0, 1);
    end
    if (end_p === 1'b0 && end_n === 1'b1)
      chk("index", idx_n, 1);
    if (cyc == 60000)
    begin
      errors++;
      end_of_test();
    end
  end
  initial
  begin
    mth_result_s r;
    logic [3:0] p;
    logic seen_end;
    logic seen_pass;
    int b;
    void'($urandom(83));
    repeat (4) @(posedge clk_in);
    chk("reset", {end_n, idx_n, j}, 8'h00);
    nrst_in <= 1'b1;
    rd_chk(`MTH_A_STATUS, 32'h0, 32'hF);
    rd_chk(`MTH_A_INTEG, 32'h1, '1);
    rd_chk(`MTH_A_EOMW, 32'h1, '1);
    wr_reg(8'hF0, '1);
    rd_chk(8'hF0, 32'h0, '1);
    wr_reg(`MTH_A_CMD, 32'h1);
    t_enter = cyc;
    repeat (3) @(posedge clk_in);
    chk("enter", {end_n, idx_n, j}, 8'h3F);
    rd_chk(`MTH_A_STATUS, 32'h1, 32'hF);
    for (int k = 0; k < 4; k++)
    begin
      cfg(k);
      r = $urandom;
      b = cs[k][0][1] ? LOWC : 0;
      run(cs[k][5], b + 1, b + 5, 1'b0, k == 1, 1'b0, r, r.pass);
    end
    cfg(0);
    wr_reg(`MTH_A_CTRL, 32'h40);
    wr_reg(`MTH_A_SHIFT, 32'h200);
    for (int k = 0; k < 7; k++)
    begin
      if (k == 3)
        wr_reg(`MTH_A_CMD, 32'h2);
      if (k == 6)
        wr_reg(`MTH_A_CMD, 32'h4);
      r = $urandom & 6'h38;
      b = k < 3 ? 0 : (k < 6 ? 3 : 6);
      p[k % 4] = r.pass;
      run(16, 1, 5, 1'b0, 1'b0, 1'b0, r,
        k - b >= 2 ? p[(k - 2) % 4] : 1'b0);
    end
    lock <= 1'b1;
    kick();
    seen_end = 1'b0;
    repeat (200)
    begin
      @(posedge clk_in);
      seen_end = seen_end | end_n;
    end
    chk("locked", seen_end, 0);
    lock <= 1'b0;
    cfg(0);
    while (cyc < t_enter + 1500 * T + 100)
      @(posedge clk_in);
    r = $urandom;
    run(16, 100, 14000, 1'b0, 1'b0, 1'b1, r, r.pass);
    cfg(4);
    r = $urandom;
    run(10, 1, 5, 1'b1, 1'b0, 1'b0, r, r.pass);
    res <= 6'h10;
    wr_reg(`MTH_A_CTRL, 32'h41);
    repeat (20 * T) @(posedge clk_in);
    seen_end = 1'b0;
    seen_pass = 1'b0;
    repeat (300)
    begin
      @(posedge clk_in);
      seen_end = seen_end | !end_n;
      seen_pass = seen_pass | j[4];
    end
    chk("free_run", seen_end, 0);
    chk("kept", seen_pass, 0);
    end_of_test();
  end
endmodule : tb
